// [rtl/rac_top.sv]
// The Avalon-MM register port was chosen for this implementation.
`default_nettype none
// What this block does
// RULE1: write one aborts; zero ignored; reads zero
// RULE2: abort halts reception, clears active flag
// RULE3: abort acts in buffered uart mode
// RULE4: software never aborts in other modes
// RULE5: abort also acts during lin master reception
// RULE6: after abort no byte enters the buffer
// RULE7: software waits for uart active flag low
// RULE8: abort register zero on reset, power off
// RULE9: register accessed only as 16-bit word
// RULE10: rx request self-clears when storage begins
// RULE11: abort while idle does nothing else; in buffered uart mode the code also drops a pending rx request
module rac_top #(
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [rac_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // bytes from the uart core
   input wire logic [DATA_W-1:0] uart_rx_data,
   input wire logic uart_rx_valid,
   output logic uart_rx_ready,
   input wire logic uart_rx_busy,
   // bytes to the receive buffer
   output logic [DATA_W-1:0] buf_data,
   output logic buf_valid,
   input wire logic buf_ready
);
   rac_pkg::rac_state_t state, next_state;
   logic power, next_power;
   logic [1:0] mode, next_mode;
   logic rx_request, next_rx_request;
   logic acked, next_acked;
   logic [31:0] next_readdata;
   logic [DATA_W-1:0] sk_d0, sk_d1, next_sk_d0, next_sk_d1;
   logic [1:0] sk_cnt, next_sk_cnt;
   logic busy_m, busy_s;
   logic req, wr_ok, abort_wr, abort_ok, store, pop;
   logic rxreq_set;
   // uart busy flag comes from another block's pins, so synchronise it
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         busy_m <= 1'b0;
         busy_s <= 1'b0;
      end else begin
         busy_m <= uart_rx_busy;
         busy_s <= busy_m;
      end
   end
   // one wait state per access: answer on the edge after acked rises;
   // a write lands only on the edge where waitrequest is low
   assign req = (read | write) & ~acked;
   assign wr_ok = write & acked
                  & (byteenable == rac_pkg::BE_HALF); // see RULE9
   assign abort_wr = wr_ok & (address == rac_pkg::OFS_ABORT)
                     & writedata[rac_pkg::BIT_ABORT]; // see RULE1
   // other modes are software's concern; lin master only outside idle (rx or drain)
   assign abort_ok = abort_wr & (mode == rac_pkg::MODE_UART_BUF
                     | (mode == rac_pkg::MODE_LIN_MASTER
                        && state != rac_pkg::RAC_IDLE)); // see RULE3 RULE4 RULE5
   assign store = uart_rx_valid & uart_rx_ready & (state == rac_pkg::RAC_RX);
   assign pop = buf_valid & buf_ready;
   assign rxreq_set = wr_ok & (address == rac_pkg::OFS_RXREQ)
                      & writedata[rac_pkg::BIT_RXREQ]
                      & (mode == rac_pkg::MODE_UART_BUF);
   always_comb begin
      next_acked = req;
      next_readdata = 32'h0000_0000;
      next_power = power;
      next_mode = mode;
      next_rx_request = rx_request;
      next_state = state;
      if (read & ~acked) begin
         unique case (address)
            rac_pkg::OFS_CTRL: begin
               next_readdata[rac_pkg::BIT_POWER] = power;
               next_readdata[rac_pkg::BIT_MODE_LO +: 2] = mode;
            end
            rac_pkg::OFS_STATUS: begin
               // draining no longer counts as receiving, see RULE2
               next_readdata[rac_pkg::BIT_RXACT] = (state == rac_pkg::RAC_RX);
               next_readdata[rac_pkg::BIT_UART_RXACT] = busy_s;
            end
            rac_pkg::OFS_RXREQ: next_readdata[rac_pkg::BIT_RXREQ] = rx_request;
            default: next_readdata = 32'h0000_0000; // abort bit reads 0, see RULE1
         endcase
      end
      if (wr_ok && address == rac_pkg::OFS_CTRL) begin
         next_power = writedata[rac_pkg::BIT_POWER];
         next_mode = writedata[rac_pkg::BIT_MODE_LO +: 2];
      end
      unique case (state)
         rac_pkg::RAC_IDLE: if (rx_request) next_state = rac_pkg::RAC_RX;
         rac_pkg::RAC_RX: if (store) next_rx_request = 1'b0; // see RULE10
         rac_pkg::RAC_DRAIN: if (!busy_s) next_state = rac_pkg::RAC_IDLE;
      endcase
      // a request written as a byte is stored survives: set wins
      if (rxreq_set) next_rx_request = 1'b1;
      if (mode == rac_pkg::MODE_LIN_MASTER && state == rac_pkg::RAC_IDLE
          && uart_rx_valid)
         next_state = rac_pkg::RAC_RX;
      // abort from idle leaves state idle, see RULE11
      // a pending request is dropped too, so idle cannot enter rx
      if (abort_ok) begin
         next_rx_request = 1'b0;
         if (state == rac_pkg::RAC_IDLE) next_state = rac_pkg::RAC_IDLE;
         else next_state = rac_pkg::RAC_DRAIN; // see RULE2 RULE6
      end
      if (!next_power) begin
         next_state = rac_pkg::RAC_IDLE; // see RULE8
         next_rx_request = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= rac_pkg::RAC_IDLE; // see RULE8
         power <= 1'b0;
         mode <= rac_pkg::MODE_LIN_MASTER;
         rx_request <= 1'b0;
         acked <= 1'b0;
         readdata <= 32'h0000_0000;
         waitrequest <= 1'b1;
      end else begin
         state <= next_state;
         power <= next_power;
         mode <= next_mode;
         rx_request <= next_rx_request;
         acked <= next_acked;
         readdata <= next_readdata;
         waitrequest <= ~next_acked;
      end
   end
   // two-entry skid: ready depends only on state and occupancy, so a stall loses nothing
   always_comb begin
      next_sk_d0 = sk_d0;
      next_sk_d1 = sk_d1;
      next_sk_cnt = sk_cnt;
      unique case ({store, pop})
         2'b10: begin
            if (sk_cnt == 2'h0) next_sk_d0 = uart_rx_data;
            else next_sk_d1 = uart_rx_data;
            next_sk_cnt = sk_cnt + 2'h1;
         end
         2'b01: begin
            next_sk_d0 = sk_d1;
            next_sk_cnt = sk_cnt - 2'h1;
         end
         2'b11: begin
            if (sk_cnt == 2'h1) next_sk_d0 = uart_rx_data;
            else begin
               next_sk_d0 = sk_d1;
               next_sk_d1 = uart_rx_data;
            end
         end
         default: next_sk_cnt = sk_cnt;
      endcase
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sk_d0 <= '0;
         sk_d1 <= '0;
         sk_cnt <= 2'h0;
         uart_rx_ready <= 1'b0;
         buf_valid <= 1'b0;
      end else begin
         sk_d0 <= next_sk_d0;
         sk_d1 <= next_sk_d1;
         sk_cnt <= next_sk_cnt;
         // draining takes and drops the core's last byte, so a later
         // lin master entry cannot store it
         uart_rx_ready <= (next_state == rac_pkg::RAC_DRAIN)
            | (next_state == rac_pkg::RAC_RX && next_sk_cnt != 2'h2);
         buf_valid <= (next_sk_cnt != 2'h0);
      end
   end
   assign buf_data = sk_d0;

   abort_stops_store_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      abort_ok && state != rac_pkg::RAC_IDLE |=> !store [*2]) // see RULE6
      else $error("byte stored after abort");
   abort_clears_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      abort_ok && power |=> state != rac_pkg::RAC_RX) // see RULE2
      else $error("rx active after abort");
   abort_reads_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      read && !acked && address == rac_pkg::OFS_ABORT
      |=> readdata == 32'h0) // see RULE1
      else $error("abort reg read nonzero");
   power_off_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !power |-> state == rac_pkg::RAC_IDLE && !rx_request) // see RULE8
      else $error("state alive while powered off");
   rxreq_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      store && !rxreq_set |=> !rx_request) // see RULE10
      else $error("rx request not cleared");
   idle_abort_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      abort_wr && state == rac_pkg::RAC_IDLE && !uart_rx_valid && power
      |=> state == rac_pkg::RAC_IDLE) // see RULE11
      else $error("idle abort changed state");
   wait_one_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(read | write) |=> !waitrequest) // one wait state per access
      else $error("answer not after one wait");
   drain_exit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state == rac_pkg::RAC_DRAIN && !busy_s && power
      |=> state == rac_pkg::RAC_IDLE) // see RULE7
      else $error("drain did not end");
   skid_full_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      sk_cnt == 2'h2 |-> !store)
      else $error("store into full buffer");
   drain_flag_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state == rac_pkg::RAC_DRAIN && read && !acked
      && address == rac_pkg::OFS_STATUS
      |=> !readdata[rac_pkg::BIT_RXACT]) // see RULE2
      else $error("rx active flag set while draining");
   abort_cov: cover property (@(posedge ref_clk) abort_ok
      && state == rac_pkg::RAC_RX);
   stall_cov: cover property (@(posedge ref_clk) sk_cnt == 2'h2);
   lin_cov: cover property (@(posedge ref_clk) abort_ok
      && mode == rac_pkg::MODE_LIN_MASTER);
   drop_cov: cover property (@(posedge ref_clk) state == rac_pkg::RAC_DRAIN
      && uart_rx_valid && uart_rx_ready);
   idle_abort_cov: cover property (@(posedge ref_clk) abort_ok
      && state == rac_pkg::RAC_IDLE);
endmodule : rac_top
`default_nettype wire

// [rtl/rac_pkg.sv]
`default_nettype none
package rac_pkg;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFS_ABORT = 8'hfc;
   localparam logic [7:0] OFS_CTRL = 8'hf0;
   localparam logic [7:0] OFS_STATUS = 8'hf4;
   localparam logic [7:0] OFS_RXREQ = 8'hf8;
   // field positions
   localparam int BIT_ABORT = 0;
   localparam int BIT_POWER = 0;
   localparam int BIT_MODE_LO = 1;
   localparam int BIT_RXACT = 0;
   localparam int BIT_UART_RXACT = 1;
   localparam int BIT_RXREQ = 4;
   localparam logic [15:0] RST_ABORT = 16'h0000;
   // adaptor modes
   localparam logic [1:0] MODE_LIN_MASTER = 2'h0;
   localparam logic [1:0] MODE_LIN_SLAVE = 2'h1;
   localparam logic [1:0] MODE_UART_BUF = 2'h2;
   localparam logic [1:0] MODE_UART_THRU = 2'h3;
   // 16-bit register: lanes 0 and 1 both required
   localparam logic [3:0] BE_HALF = 4'h3;
   typedef enum logic [1:0] {RAC_IDLE, RAC_RX, RAC_DRAIN} rac_state_t;
endpackage : rac_pkg
`default_nettype wire

// [sim/rac_uart_model.sv]
`default_nettype none
module rac_uart_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // frame request from the bench
   input wire logic go,
   input wire logic [7:0] byte_in,
   // byte stream toward the adaptor
   output logic [7:0] data,
   output logic valid,
   output logic busy,
   input wire logic ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt;
   logic [7:0] held;
   // off-beat data is inverted so a stale byte never looks valid
   assign data = valid ? held : ~held;
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 3'h0;
         busy <= 1'b0;
         valid <= 1'b0;
         held <= 8'h00;
      end else begin
         if (valid && ready) valid <= 1'b0;
         if (go) begin
            cnt <= 3'h6;
            busy <= 1'b1;
            held <= byte_in;
         end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            // a started frame always completes, abort or not
            if (cnt == 3'h1) begin
               busy <= 1'b0;
               valid <= 1'b1;
            end
         end
      end
   end
endmodule : rac_uart_model
`default_nettype wire

// [sim/tb_top.sv]
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic mrst_n = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'h3;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic waitrequest, u_valid, u_ready, u_busy, buf_valid;
   logic buf_ready = 1'b1;
   logic go = 1'b0;
   logic [7:0] gob = 8'h00, u_data, buf_data;
   logic [7:0] got[$];
   // register address beside its expected reset read value
   logic [39:0] rows[5] = '{40'hf000000000, 40'hf400000000,
      40'hf800000000, 40'hfc00000000, 40'h0000000000};
   int num_errors = 0, check_count = 0, cyc = 0;
   always #25 ref_clk = ~ref_clk;
   rac_top dut (.ref_clk, .nrst, .address, .read, .write, .byteenable,
      .writedata, .readdata, .waitrequest, .uart_rx_data(u_data),
      .uart_rx_valid(u_valid), .uart_rx_ready(u_ready),
      .uart_rx_busy(u_busy), .buf_data, .buf_valid, .buf_ready);
   rac_uart_model uart (.ref_clk, .nrst(nrst && mrst_n), .go,
      .byte_in(gob), .data(u_data), .valid(u_valid), .busy(u_busy),
      .ready(u_ready));
   always @(posedge ref_clk) begin
      if (buf_valid === 1'b1 && buf_ready === 1'b1) got.push_back(buf_data);
      cyc++;
      if (cyc == 4000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %0t saw %h expected %h", $time, s, e);
      end
   endtask : chk
   // holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      byteenable <= be;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   task automatic send(input logic [7:0] b);
      @(posedge ref_clk);
      go <= 1'b1;
      gob <= b;
      @(posedge ref_clk);
      go <= 1'b0;
   endtask : send
   // e: status right after the abort (bit1 set while the core still runs)
   task automatic abort_and_wait(input logic [31:0] e);
      bus(1'b1, 8'hfc, 32'h1, 4'h3);
      bus(1'b0, 8'hf4, 32'h0, 4'h3);
      chk(q, e);
      while (q[1:0] !== 2'b00) bus(1'b0, 8'hf4, 32'h0, 4'h3);
      chk(q, 32'h0);
   endtask : abort_and_wait
   initial begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         bus(1'b0, rows[i][39:32], 32'h0, 4'h3);
         chk(q, rows[i][31:0]);
      end
      bus(1'b1, 8'hf0, 32'h5, 4'h3);
      bus(1'b1, 8'hf8, 32'h10, 4'h1);
      bus(1'b0, 8'hf4, 32'h0, 4'h3);
      chk(q, 32'h0);
      bus(1'b1, 8'hf8, 32'h10, 4'h3);
      bus(1'b1, 8'hfc, 32'h0, 4'h3);
      bus(1'b0, 8'hf4, 32'h0, 4'h3);
      chk(q[0], 1'b1);
      buf_ready <= 1'b0;
      send(8'ha1);
      repeat (10) @(posedge ref_clk);
      send(8'h5e);
      repeat (10) @(posedge ref_clk);
      chk(u_ready, 1'b0); // buffer full stalls the core
      bus(1'b0, 8'hf8, 32'h0, 4'h3);
      chk(q, 32'h0);
      buf_ready <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk({got[0], got[1]}, 16'ha15e);
      send(8'h3c);
      abort_and_wait(32'h2);
      chk(got.size(), 2);
      chk(u_valid, 1'b0);
      mrst_n <= 1'b0;
      @(posedge ref_clk);
      mrst_n <= 1'b1;
      abort_and_wait(32'h0);
      bus(1'b1, 8'hf0, 32'h1, 4'h3);
      send(8'h77);
      repeat (12) @(posedge ref_clk);
      chk(got.size(), 3);
      send(8'h88);
      abort_and_wait(32'h2);
      chk(got.size(), 3);
      bus(1'b1, 8'hf0, 32'h0, 4'h3);
      bus(1'b0, 8'hfc, 32'h0, 4'h3);
      chk(q, 32'h0);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
